//--- pkg/dcc_pkg.sv
// constants for the common configuration word and its serial link
// assumes a single 20 MHz core clock; link edges are sampled on it
package dcc_pkg;
  // ----------------------------------------
  // word layout and reset value
  // ----------------------------------------
  localparam int          CFG_W     = 48;
  localparam logic [47:0] CFG_RESET = 48'h2000_E000_0107;
  localparam int CASC_LSB  = 0;
  localparam int PDC_BIT   = 8;
  localparam int PS_BIT    = 12;
  localparam int PSP_LSB   = 13;
  localparam int OLR_BIT   = 15;
  localparam int SCAN_LSB  = 16;
  localparam int SUBP_LSB  = 22;
  localparam int RANGE_BIT = 28;
  localparam int MUL_LSB   = 29;
  localparam int DLYR_LSB  = 36;
  localparam int DLYG_LSB  = 39;
  localparam int DLYB_LSB  = 42;
  localparam int SLR_BIT   = 47;
  // ----------------------------------------
  // link command codes and counts
  // ----------------------------------------
  localparam int          CMD_W     = 16;
  localparam logic [15:0] CMD_WRITE = 16'hAA00;
  localparam logic [15:0] CMD_READ  = 16'hAA60;
  localparam logic [5:0]  LAST_BIT  = 6'h2F;
  // power saving plus thresholds in eighths of a segment
  localparam logic [2:0]  PSP_OFF   = 3'h0;
  localparam logic [2:0]  PSP_QTR   = 3'h2;
  localparam logic [2:0]  PSP_HALF  = 3'h4;
  localparam logic [2:0]  PSP_7_8   = 3'h7;
  typedef enum logic [1:0] {
    ST_HUNT  = 2'b00,
    ST_WDATA = 2'b01,
    ST_RDATA = 2'b11
  } dcc_state_t;
endpackage

//--- pkg/dcc_link_if.sv
// word path between the serial link engine and the config core
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface dcc_link_if;
  logic        wr_commit;
  logic [47:0] wr_data;
  logic [47:0] rd_data;
  modport link (output wr_commit, output wr_data, input rd_data);
  modport core (input wr_commit, input wr_data, output rd_data);
endinterface
`default_nettype wire

//--- core/dcc_link.sv
// serial command engine: dual-edge receive, write capture, readback
// assumes sclk and sin come from pins, foreign to mclk
`timescale 1ns/1ps
`default_nettype none
module dcc_link
  import dcc_pkg::*;
(
  input  wire logic mclk,   // core clock
  input  wire logic rst,    // sync reset
  input  wire logic sclk,   // link clock pin
  input  wire logic sin,    // link data in
  output logic      sout,   // link data out
  dcc_link_if.link  lnk     // word path
);
  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic sclk_m, sclk_s, sclk_d, sin_m, sin_s;
  logic edge_seen;
  always_ff @(posedge mclk) begin
    if (rst) begin
      {sclk_m, sclk_s, sclk_d, sin_m, sin_s} <= 5'h00;
    end else begin
      {sclk_m, sclk_s, sclk_d} <= {sclk, sclk_m, sclk_s};
      {sin_m, sin_s}           <= {sin, sin_m};
    end
  end
  // both link edges carry a bit
  assign edge_seen = sclk_s ^ sclk_d;

  // ----------------------------------------
  // command state machine
  // ----------------------------------------
  dcc_state_t  st, next_st;
  logic [5:0]  cnt, next_cnt;
  logic [47:0] sh, next_sh, osh, next_osh, next_wdata;
  logic        next_sout, next_commit;
  logic [15:0] cmd_now;
  assign cmd_now = {sh[14:0], sin_s};
  // next values; shifter cleared on exit so data never aliases a command
  always_comb begin
    next_st     = st;
    next_cnt    = cnt;
    next_sh     = edge_seen ? {sh[46:0], sin_s} : sh;
    next_osh    = osh;
    next_sout   = sout;
    next_commit = 1'b0;
    next_wdata  = lnk.wr_data;
    unique case (st)
      ST_HUNT: begin
        if (edge_seen && cmd_now == CMD_WRITE) begin
          next_st  = ST_WDATA;
          next_cnt = 6'h00;
          next_sh  = 48'h0;
        end else if (edge_seen && cmd_now == CMD_READ) begin
          next_st   = ST_RDATA;
          next_cnt  = 6'h00;
          next_sh   = 48'h0;
          next_sout = lnk.rd_data[47];
          next_osh  = {lnk.rd_data[46:0], 1'b0};
        end
      end
      ST_WDATA: begin
        if (edge_seen) begin
          next_cnt = cnt + 6'h01;
          if (cnt == LAST_BIT) begin
            next_commit = 1'b1;
            next_wdata  = {sh[46:0], sin_s};
            next_st     = ST_HUNT;
            next_sh     = 48'h0;
          end
        end
      end
      ST_RDATA: begin
        if (edge_seen) begin
          next_cnt  = cnt + 6'h01;
          next_sout = osh[47];
          next_osh  = {osh[46:0], 1'b0};
          if (cnt == LAST_BIT) begin
            next_st   = ST_HUNT;
            next_sout = 1'b0;
            next_sh   = 48'h0;
          end
        end
      end
      default: next_st = ST_HUNT;
    endcase
  end
  // registers only
  always_ff @(posedge mclk) begin
    if (rst) begin
      st            <= ST_HUNT;
      cnt           <= 6'h00;
      sh            <= 48'h0;
      osh           <= 48'h0;
      sout          <= 1'b0;
      lnk.wr_commit <= 1'b0;
      lnk.wr_data   <= 48'h0;
    end else begin
      st            <= next_st;
      cnt           <= next_cnt;
      sh            <= next_sh;
      osh           <= next_osh;
      sout          <= next_sout;
      lnk.wr_commit <= next_commit;
      lnk.wr_data   <= next_wdata;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_commit_after_48: assert property (
    @(posedge mclk) disable iff (rst)
    lnk.wr_commit |-> $past(st) == ST_WDATA && $past(cnt) == LAST_BIT)
    else $error("commit without full word");
  a_write_cmd_entry: assert property (
    @(posedge mclk) disable iff (rst)
    (st == ST_HUNT && edge_seen && cmd_now == CMD_WRITE)
      |=> st == ST_WDATA && cnt == 6'h00 && !lnk.wr_commit)
    else $error("write command not taken");
endmodule
`default_nettype wire

//--- core/dcc_config.sv
// common configuration word of the matrix led driver, with its
// frame-store line counter and subperiod segment sequencer
// assumes line_written, segment_tick and forward_pwm_mode are mclk logic
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - bits 4..0 hold cascade count; code n means n+1 devices.
// - bit 8 enables pre-discharge; resets to one.
// - bit 12 enables power saving; resets to zero.
// - bits 14..13 select power saving plus threshold: off, 1/4, 1/2, 7/8.
// - bit 15 enables open led removal; resets to zero.
// - bits 21..16 give scan lines as code plus one; reset zero.
// - bits 24..22 give sixteen times code plus one subperiods.
// - bit 28 picks multiplier range, low 40-80 or high 80-160 MHz.
// - bits 32..29 make grayscale clock code+1 times link clock; reset eight.
// - three-bit colour group delays, active only in forward pwm mode.
// - bit 47 enables short led caterpillar removal; resets to zero.
// - line counter advances per stored line, wraps after the last scan line.
// - each subperiod splits into one segment per scan line.
module dcc_config
  import dcc_pkg::*;
(
  input  wire logic  mclk,                     // core clock, 20 MHz
  input  wire logic  rst,                      // sync reset, high
  input  wire logic  sclk,                     // link clock pin
  input  wire logic  sin,                      // link data in
  output logic       sout,                     // link data out
  input  wire logic  line_written,             // one line stored
  input  wire logic  segment_tick,             // one segment ended
  input  wire logic  forward_pwm_mode,         // pwm runs forward
  output logic [4:0] cascade_count,            // chain code
  output logic       predischarge_enable,      // pre-discharge on
  output logic       power_saving_enable,      // power saving on
  output logic [1:0] power_saving_plus_select, // plus mode code
  output logic       open_led_removal_enable,  // open removal on
  output logic [5:0] scan_line_count,          // scan code
  output logic [2:0] subperiod_count,          // subperiod code
  output logic       multiplier_range_select,  // high range
  output logic [3:0] multiplier_factor,        // multiplier code
  output logic [2:0] red_group_delay,          // red delay code
  output logic [2:0] green_group_delay,        // green delay code
  output logic [2:0] blue_group_delay,         // blue delay code
  output logic       short_led_removal_enable, // short removal on
  output logic [5:0] device_total,             // devices in chain
  output logic [6:0] active_lines,             // scan lines used
  output logic [7:0] subperiods_per_frame,     // subperiods
  output logic [4:0] grayscale_clock_multiple, // clock multiple
  output logic [2:0] psp_threshold_eighths,    // plus threshold
  output logic [2:0] red_delay_active,         // applied red delay
  output logic [2:0] green_delay_active,       // applied green delay
  output logic [2:0] blue_delay_active,        // applied blue delay
  output logic [5:0] line_count,               // store line
  output logic       frame_stored,             // frame done pulse
  output logic [5:0] segment_index,            // segment in subperiod
  output logic [6:0] subperiod_index,          // subperiod in frame
  output logic       frame_shown               // last segment pulse
);
  // ----------------------------------------
  // link engine
  // ----------------------------------------
  dcc_link_if lnk ();
  dcc_link u_link (
    .mclk (mclk),
    .rst  (rst),
    .sclk (sclk),
    .sin  (sin),
    .sout (sout),
    .lnk  (lnk.link)
  );

  // ----------------------------------------
  // configuration word
  // ----------------------------------------
  logic [47:0] cfg, next_cfg;
  // reserved bits stored as written; the controller keeps them at reset
  // atomic update
  always_comb begin
    next_cfg = lnk.wr_commit ? lnk.wr_data : cfg;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg <= CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end
  assign lnk.rd_data = cfg;

  // field views, each straight off the word register
  // cascade code
  assign cascade_count            = cfg[CASC_LSB +: 5];
  assign predischarge_enable      = cfg[PDC_BIT];
  assign power_saving_enable      = cfg[PS_BIT];
  assign power_saving_plus_select = cfg[PSP_LSB +: 2];
  assign open_led_removal_enable  = cfg[OLR_BIT];
  assign scan_line_count          = cfg[SCAN_LSB +: 6];
  assign subperiod_count          = cfg[SUBP_LSB +: 3];
  assign multiplier_range_select  = cfg[RANGE_BIT];
  assign multiplier_factor        = cfg[MUL_LSB +: 4];
  assign red_group_delay          = cfg[DLYR_LSB +: 3];
  assign green_group_delay        = cfg[DLYG_LSB +: 3];
  assign blue_group_delay         = cfg[DLYB_LSB +: 3];
  assign short_led_removal_enable = cfg[SLR_BIT];

  // ----------------------------------------
  // decoded settings
  // ----------------------------------------
  logic [5:0] next_dev;
  logic [6:0] next_lines;
  logic [7:0] next_subp;
  logic [4:0] next_mul;
  logic [2:0] next_psp, next_dr, next_dg, next_db;
  // decoded one cycle after the word, so every output is a flop
  always_comb begin
    next_dev   = {1'b0, cascade_count} + 6'h01;
    next_lines = {1'b0, scan_line_count} + 7'h01;
    next_subp  = {({1'b0, subperiod_count} + 4'h1), 4'h0};
    next_mul   = {1'b0, multiplier_factor} + 5'h01;
    unique case (power_saving_plus_select)
      2'h0: next_psp = PSP_OFF;
      2'h1: next_psp = PSP_QTR;
      2'h2: next_psp = PSP_HALF;
      2'h3: next_psp = PSP_7_8;
    endcase
    next_dr = forward_pwm_mode ? red_group_delay   : 3'h0;
    next_dg = forward_pwm_mode ? green_group_delay : 3'h0;
    next_db = forward_pwm_mode ? blue_group_delay  : 3'h0;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      device_total          <= 6'h00;
      active_lines          <= 7'h00;
      subperiods_per_frame  <= 8'h00;
      grayscale_clock_multiple <= 5'h00;
      psp_threshold_eighths <= 3'h0;
      red_delay_active      <= 3'h0;
      green_delay_active    <= 3'h0;
      blue_delay_active     <= 3'h0;
    end else begin
      device_total          <= next_dev;
      active_lines          <= next_lines;
      subperiods_per_frame  <= next_subp;
      grayscale_clock_multiple <= next_mul;
      psp_threshold_eighths <= next_psp;
      red_delay_active      <= next_dr;
      green_delay_active    <= next_dg;
      blue_delay_active     <= next_db;
    end
  end

  // ----------------------------------------
  // frame store and display sequencing
  // ----------------------------------------
  logic [5:0] next_line, next_seg;
  logic [6:0] next_sidx, subp_last;
  logic       next_fstore, next_fshow;
  // a scan change mid-frame takes effect at the next compare
  assign subp_last = {subperiod_count, 4'hF};
  always_comb begin
    next_line   = line_count;
    next_fstore = 1'b0;
    next_seg    = segment_index;
    next_sidx   = subperiod_index;
    next_fshow  = 1'b0;
    if (line_written) begin
      if (line_count >= scan_line_count) begin
        next_line   = 6'h00;
        next_fstore = 1'b1;
      end else begin
        next_line = line_count + 6'h01;
      end
    end
    if (segment_tick) begin
      if (segment_index >= scan_line_count) begin
        next_seg = 6'h00;
        if (subperiod_index >= subp_last) begin
          next_sidx  = 7'h00;
          next_fshow = 1'b1;
        end else begin
          next_sidx = subperiod_index + 7'h01;
        end
      end else begin
        next_seg = segment_index + 6'h01;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      line_count      <= 6'h00;
      frame_stored    <= 1'b0;
      segment_index   <= 6'h00;
      subperiod_index <= 7'h00;
      frame_shown     <= 1'b0;
    end else begin
      line_count      <= next_line;
      frame_stored    <= next_fstore;
      segment_index   <= next_seg;
      subperiod_index <= next_sidx;
      frame_shown     <= next_fshow;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_cfg_commit: assert property (
    @(posedge mclk) disable iff (rst)
    lnk.wr_commit |=> cfg == $past(lnk.wr_data))
    else $error("word not taken on commit");
  a_cfg_hold: assert property (
    @(posedge mclk) disable iff (rst)
    !lnk.wr_commit |=> $stable(cfg))
    else $error("word changed without commit");
  a_reset_word: assert property (
    @(posedge mclk) disable iff (rst)
    $fell(rst) |-> predischarge_enable && cfg == CFG_RESET
      && !power_saving_enable && !short_led_removal_enable)
    else $error("wrong word after reset");
  a_dev_total: assert property (
    @(posedge mclk) disable iff (rst)
    lnk.wr_commit ##2 1'b1 |-> device_total == $past(lnk.wr_data[4:0], 2) + 6'h01)
    else $error("device total not code plus one");
  a_lines_mul: assert property (
    @(posedge mclk) disable iff (rst)
    !$past(rst) |-> grayscale_clock_multiple == $past(multiplier_factor) + 5'h01
      && active_lines == $past(scan_line_count) + 7'h01)
    else $error("clock multiple or line count wrong");
  a_psp_thresh: assert property (
    @(posedge mclk) disable iff (rst)
    power_saving_plus_select == 2'h3 ##1 $stable(cfg) |-> psp_threshold_eighths == 3'h7)
    else $error("seven eighths threshold wrong");
  a_grp_delay: assert property (
    @(posedge mclk) disable iff (rst)
    !forward_pwm_mode |=> red_delay_active == 3'h0 && blue_delay_active == 3'h0)
    else $error("group delay outside forward mode");
  a_line_wrap: assert property (
    @(posedge mclk) disable iff (rst)
    line_written && line_count == scan_line_count |=> line_count == 6'h00 && frame_stored)
    else $error("line counter did not wrap");
  a_subp_wrap: assert property (
    @(posedge mclk) disable iff (rst)
    segment_tick && segment_index == scan_line_count && subperiod_index == subp_last
      |=> segment_index == 6'h00 && subperiod_index == 7'h00 && frame_shown)
    else $error("subperiod sequence did not wrap");
  a_cascade_commit: assert property (
    @(posedge mclk) disable iff (rst)
    lnk.wr_commit |=> cascade_count == $past(lnk.wr_data[CASC_LSB +: 5]))
    else $error("cascade code not taken");
  a_ps_commit: assert property (
    @(posedge mclk) disable iff (rst)
    lnk.wr_commit |=> power_saving_enable == $past(lnk.wr_data[PS_BIT]))
    else $error("power saving bit not taken");
  a_psp_quarter: assert property (
    @(posedge mclk) disable iff (rst)
    power_saving_plus_select == 2'h1 ##1 $stable(cfg) |-> psp_threshold_eighths == 3'h2)
    else $error("quarter threshold wrong");
  a_olr_commit: assert property (
    @(posedge mclk) disable iff (rst)
    lnk.wr_commit |=> open_led_removal_enable == $past(lnk.wr_data[OLR_BIT]))
    else $error("open removal bit not taken");
  a_scan_commit: assert property (
    @(posedge mclk) disable iff (rst)
    lnk.wr_commit |=> scan_line_count == $past(lnk.wr_data[SCAN_LSB +: 6]))
    else $error("scan code not taken");
  a_subp_total: assert property (
    @(posedge mclk) disable iff (rst)
    !$past(rst) |-> subperiods_per_frame == ({1'b0, $past(subperiod_count)} + 4'h1) * 8'h10)
    else $error("subperiod total wrong");
  a_range_commit: assert property (
    @(posedge mclk) disable iff (rst)
    lnk.wr_commit |=> multiplier_range_select == $past(lnk.wr_data[RANGE_BIT]))
    else $error("range bit not taken");
  a_delay_fwd: assert property (
    @(posedge mclk) disable iff (rst)
    forward_pwm_mode |=> green_delay_active == $past(green_group_delay))
    else $error("group delay lost in forward mode");
  a_short_commit: assert property (
    @(posedge mclk) disable iff (rst)
    lnk.wr_commit |=> short_led_removal_enable == $past(lnk.wr_data[SLR_BIT]))
    else $error("short removal bit not taken");
  a_line_step: assert property (
    @(posedge mclk) disable iff (rst)
    line_written && line_count < scan_line_count
      |=> line_count == $past(line_count) + 6'h01 && !frame_stored)
    else $error("line counter did not step");
  a_seg_step: assert property (
    @(posedge mclk) disable iff (rst)
    segment_tick && segment_index < scan_line_count
      |=> segment_index == $past(segment_index) + 6'h01
      && subperiod_index == $past(subperiod_index))
    else $error("segment counter did not step");
endmodule
`default_nettype wire

//--- tb/dcc_ctrl_model.sv
// display controller model: drives the three-wire command link
// assumes the device samples sclk and sin on its own core clock
`timescale 1ns/1ps
`default_nettype none
module dcc_ctrl_model (
  output logic     sclk, // link clock, still between frames
  output logic     sin,  // link data
  input  wire logic sout // readback data
);
  initial begin
    sclk = 1'b0;
    sin  = 1'b0;
  end
  // ----------------------------------------
  // bit transfer
  // ----------------------------------------
  // sin moves mid half-period so it is steady around every edge;
  // sout is sampled just before each edge, where it has settled
  task automatic xfer(input logic [63:0] v, input int n, output logic [47:0] rd);
    rd = 48'h0;
    for (int i = n - 1; i >= 0; i--) begin
      #100;
      sin = v[i];
      #100;
      rd = {rd[46:0], sout};
      sclk = ~sclk;
    end
    #100;
    // released line shows the inverse, so a stale value cannot pass
    sin = ~sin;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_display_common_config.sv
// self-checking bench for the common configuration word
// assumes a 20 MHz core clock and a 400 ns link clock from the model
`timescale 1ns/1ps
`default_nettype none
module tb_display_common_config;
  import dcc_pkg::*;
  // reset word worked out from the field table
  localparam logic [47:0] RST_WORD = 48'h2000_E000_0107;
  localparam logic [47:0] W1       = 48'hBD11_F1FF_B01F;
  localparam logic [47:0] W2       = 48'h2070_0000_4100;
  localparam logic [47:0] W3       = 48'h2E80_E0DF_610F;
  localparam logic [47:0] W4       = 48'h2000_E002_0107;
  logic       mclk = 1'b0, rst = 1'b1;
  logic       line_written = 1'b0, segment_tick = 1'b0, forward_pwm_mode = 1'b0;
  wire logic  sclk, sin;
  logic       sout, predischarge_enable, power_saving_enable, open_led_removal_enable;
  logic       multiplier_range_select, short_led_removal_enable, frame_stored, frame_shown;
  logic [4:0] cascade_count, grayscale_clock_multiple;
  logic [1:0] power_saving_plus_select;
  logic [5:0] scan_line_count, device_total, line_count, segment_index;
  logic [2:0] subperiod_count, red_group_delay, green_group_delay, blue_group_delay;
  logic [3:0] multiplier_factor;
  logic [6:0] active_lines, subperiod_index;
  logic [7:0] subperiods_per_frame;
  logic [2:0] psp_threshold_eighths, red_delay_active, green_delay_active, blue_delay_active;
  int         num_errors = 0;
  int         check_count = 0;
  dcc_config uut (
    .mclk, .rst, .sclk, .sin, .sout, .line_written, .segment_tick, .forward_pwm_mode,
    .cascade_count, .predischarge_enable, .power_saving_enable, .power_saving_plus_select,
    .open_led_removal_enable, .scan_line_count, .subperiod_count, .multiplier_range_select,
    .multiplier_factor, .red_group_delay, .green_group_delay, .blue_group_delay,
    .short_led_removal_enable, .device_total, .active_lines, .subperiods_per_frame,
    .grayscale_clock_multiple, .psp_threshold_eighths, .red_delay_active, .green_delay_active,
    .blue_delay_active, .line_count, .frame_stored, .segment_index, .subperiod_index,
    .frame_shown
  );
  dcc_ctrl_model ctrl (.sclk(sclk), .sin(sin), .sout(sout));
  // 50 ns core clock
  always #25 mclk = ~mclk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // link edges start off the core clock phase on purpose
  task automatic link(input logic [63:0] v, input int n, output logic [47:0] rd);
    @(negedge mclk);
    #7;
    ctrl.xfer(v, n, rd);
    repeat (6) @(negedge mclk);
  endtask
  task automatic wr(input logic [47:0] w);
    logic [47:0] d;
    link({CMD_WRITE, w}, 64, d);
  endtask
  task automatic rd_chk(input logic [47:0] exp);
    logic [47:0] d;
    link({CMD_READ, 48'h0}, 64, d);
    chk("readback", exp, d);
    chk("sout idle", 48'h0, 48'(sout));
  endtask
  // rebuilds the word from the field outputs; reserved bits come from w
  task automatic chk_word(input logic [47:0] w);
    logic [47:0] seen;
    logic [2:0]  psp_tab [4];
    psp_tab = '{3'h0, 3'h2, 3'h4, 3'h7};
    seen = {short_led_removal_enable, w[46:45], blue_group_delay, green_group_delay,
            red_group_delay, w[35:33], multiplier_factor, multiplier_range_select,
            w[27:25], subperiod_count, scan_line_count, open_led_removal_enable,
            power_saving_plus_select, power_saving_enable, w[11:9], predischarge_enable,
            w[7:5], cascade_count};
    chk("fields", w, seen);
    chk("devices", 48'({1'b0, w[4:0]} + 6'h01), 48'(device_total));
    chk("lines", 48'({1'b0, w[21:16]} + 7'h01), 48'(active_lines));
    chk("subperiods", 48'({5'h0, w[24:22]} + 8'h01) * 48'h10,
        48'(subperiods_per_frame));
    chk("multiple", 48'({1'b0, w[32:29]} + 5'h01), 48'(grayscale_clock_multiple));
    chk("psp", 48'(psp_tab[w[14:13]]), 48'(psp_threshold_eighths));
    chk("delays", forward_pwm_mode ? 48'(w[44:36]) : 48'h0,
        48'({blue_delay_active, green_delay_active, red_delay_active}));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("counters", 48'h0, 48'({line_count, segment_index, subperiod_index}));
    chk_word(RST_WORD);
    rd_chk(RST_WORD);
    $display("t_reset done");
  endtask
  // reserved fields always written at their reset values
  task automatic t_fields;
    logic [47:0] tab [4];
    tab = '{W1, W2, W3, W4};
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      forward_pwm_mode = ~i[0];
      wr(tab[i]);
      chk_word(tab[i]);
      rd_chk(tab[i]);
    end
    $display("t_fields done");
  endtask
  // a short write must leave every field alone until its last bit
  task automatic t_partial;
    logic [47:0] d;
    link({1'b0, CMD_WRITE, W1[47:1]}, 63, d);
    chk_word(W4);
    link({63'h0, W1[0]}, 1, d);
    chk_word(W1);
    wr(W4);
    chk_word(W4);
    $display("t_partial done");
  endtask
  // three scan lines, strobes back to back
  task automatic t_lines;
    @(negedge mclk);
    line_written = 1'b1;
    for (int i = 1; i <= 4; i++) begin
      @(negedge mclk);
      chk("line_count", 48'(i % 3), 48'(line_count));
      chk("frame_stored", 48'(i == 3), 48'(frame_stored));
    end
    line_written = 1'b0;
    $display("t_lines done");
  endtask
  // three segments per subperiod, sixteen subperiods per frame
  task automatic t_segments;
    @(negedge mclk);
    segment_tick = 1'b1;
    for (int k = 1; k <= 49; k++) begin
      @(negedge mclk);
      chk("segment", 48'({6'(k % 3), 7'((k / 3) % 16)}),
          48'({segment_index, subperiod_index}));
      chk("frame_shown", 48'(k == 48), 48'(frame_shown));
    end
    segment_tick = 1'b0;
    $display("t_segments done");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // a hung run counts against the verdict
  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_fields();
    t_partial();
    t_lines();
    t_segments();
    final_report();
  end
endmodule
`default_nettype wire
